// ==== pidsc_speed_ctrl.sv ====
// pidsc_speed_ctrl: pid speed controller with avalon-mm register slave
//
// Overview of operation
// [RQ1] a proportional gain setting of 1.0 gives unity gain and 0.5 gives half gain.
// [RQ2] the gain has one decimal place up to 1000.0, or two up to 100.00 with format bit 1 set.
// [RQ3] with integral and differential settings both zero the output is the proportional term.
// [RQ4] integral time spans 0.00 to 100.00 s and exactly 0.00 disables the integral term.
// [RQ5] integral gain falls as integral time grows, and it accumulates until the error is zero.
// [RQ6] the differential term follows the error's rate of change, is zero without change, 0-1 s.
// [RQ7] software never uses the differential term alone, only with p or with p and i.
// [RQ8] the integral term is clamped at maximum frequency times the integral limit percent.
// [RQ9] the positive output is clamped at maximum frequency times the output limit percent.
// [RQ10] the integral part follows the time integral of the error.
// [RQ11] negative feedback uses set point minus feedback, positive feedback their sum.
// [RQ12] all terms update once per fixed sample period; reset clears integral and last error.
`timescale 1ns/10ps
`default_nettype none
module pidsc_speed_ctrl
  import pidsc_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYCLES_DFLT,
  parameter int FREQ_W = 17
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [REG_W-1:0] i_set_point,
  input wire logic [REG_W-1:0] i_feedback,
  output logic [FREQ_W-1:0] o_freq_cmd,
  output logic o_update
);

  // ==========================================================================
  // declarations
  logic [REG_W-1:0] cfg_q [NUM_CFG];
  logic [REG_W-1:0] wmerge_w [NUM_CFG];
  logic [NUM_CFG-1:0] hit_w;
  logic req_w;
  logic wr_fire_w;
  logic hit_freq_w;
  logic hit_iterm_w;
  logic [DATA_W-1:0] rd_mux_w;

  pidsc_state_t state_q;
  logic [$clog2(SAMPLE_CYCLES)-1:0] tick_cnt_q;
  logic tick_q;
  logic signed [MATH_W-1:0] err_w;
  logic signed [MATH_W-1:0] err_q;
  logic signed [MATH_W-1:0] prev_err_q;
  logic signed [MATH_W-1:0] dlt_q;
  logic signed [MATH_W-1:0] p_w;
  logic signed [MATH_W-1:0] p_q;
  logic signed [MATH_W-1:0] acc_q;
  logic acc_neg_q;
  logic signed [MATH_W-1:0] i_raw_q;
  logic signed [MATH_W-1:0] i_term_q;
  logic signed [MATH_W-1:0] d_q;
  logic signed [MATH_W-1:0] ti_us_w;
  logic signed [MATH_W-1:0] ilim_w;
  logic signed [MATH_W-1:0] olim_w;
  logic signed [MATH_W-1:0] i_cl_w;
  logic i_hit_w;
  logic signed [MATH_W-1:0] sum_w;
  logic signed [MATH_W-1:0] out_w;
  logic positive_fb_w;
  logic fine_gain_w;
  logic div_start_w;
  logic [MATH_W-1:0] div_num_w;
  logic [MATH_W-1:0] div_den_w;
  logic [MATH_W-1:0] acc_mag_w;
  logic [MATH_W-1:0] dlt_mag_w;
  logic div_done_w;
  logic [MATH_W-1:0] div_quot_w;

  // ==========================================================================
  // bus decode; every register is one aligned word, configuration data in the low 16 bits
  assign req_w = i_avs_read || i_avs_write;
  assign wr_fire_w = i_avs_write && !o_avs_waitrequest;
  assign hit_freq_w = i_avs_address == (IDX_FREQ_OUT << ADDR_SHIFT);
  assign hit_iterm_w = i_avs_address == (IDX_I_TERM << ADDR_SHIFT);

  // per-slot address match and byte-lane merge
  genvar g;
  for (g = 0; g < NUM_CFG; g++) begin : g_cfg
    assign hit_w[g] = i_avs_address == (CFG_IDX[g] << ADDR_SHIFT);
    assign wmerge_w[g] = {i_avs_byteenable[1] ? i_avs_writedata[15:8] : cfg_q[g][15:8],
                          i_avs_byteenable[0] ? i_avs_writedata[7:0] : cfg_q[g][7:0]};
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    rd_mux_w = '0;
    for (int k = 0; k < NUM_CFG; k++) begin
      if (hit_w[k]) begin
        rd_mux_w = DATA_W'(cfg_q[k]);
      end
    end
    if (hit_freq_w) begin
      rd_mux_w = DATA_W'(o_freq_cmd);
    end
    if (hit_iterm_w) begin
      rd_mux_w = i_term_q[DATA_W-1:0];
    end
  end

  // one wait cycle per access keeps readdata and waitrequest registered
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= '0;
    end else if (i_clk_en) begin
      o_avs_waitrequest <= !(req_w && o_avs_waitrequest);
      if (i_avs_read && o_avs_waitrequest) begin
        o_avs_readdata <= rd_mux_w;
      end
    end
  end

  // configuration registers; writes to unmapped addresses are dropped
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < NUM_CFG; k++) begin
        cfg_q[k] <= CFG_RST[k];
      end
    end else if (i_clk_en && wr_fire_w) begin
      for (int k = 0; k < NUM_CFG; k++) begin
        if (hit_w[k]) begin
          cfg_q[k] <= wmerge_w[k];
        end
      end
    end
  end

  // ==========================================================================
  // sample tick: one pulse per control period
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (i_clk_en) begin
      tick_q <= tick_cnt_q == ($clog2(SAMPLE_CYCLES))'(SAMPLE_CYCLES - 1); // RQ12
      tick_cnt_q <= (tick_cnt_q == ($clog2(SAMPLE_CYCLES))'(SAMPLE_CYCLES - 1)) ?
                    '0 : tick_cnt_q + 1'b1;
    end
  end

  // ==========================================================================
  // error, gain scaling and limits
  assign positive_fb_w = (cfg_q[SLOT_FB_SRC] == FB_POS_ANALOG) ||
                         (cfg_q[SLOT_FB_SRC] == FB_POS_PULSE) ||
                         (cfg_q[SLOT_FB_SRC] == FB_POS_PULSE_DIR) ||
                         (cfg_q[SLOT_FB_SRC] == FB_POS_COMM);
  // no feedback source selected means no error, so the proportional term is zero and the integral holds
  assign err_w = (cfg_q[SLOT_FB_SRC] == FB_NONE) ? '0 :
                 positive_fb_w ? MATH_W'(i_set_point) + MATH_W'(i_feedback) : // RQ11
                 MATH_W'(i_set_point) - MATH_W'(i_feedback); // RQ11
  assign fine_gain_w = cfg_q[SLOT_GAIN_FMT][GAIN_FMT_BIT];
  // the gain setting is a fixed-point factor; its unit value means unity gain
  // the gain is widened as a signed value so a negative error keeps its sign
  assign p_w = (err_w * $signed(MATH_W'(cfg_q[SLOT_KP]))) /
               (fine_gain_w ? MATH_W'(KP_DIV_HUNDREDTHS) : MATH_W'(KP_DIV_TENTHS)); // RQ1 RQ2
  assign ti_us_w = MATH_W'(cfg_q[SLOT_TI]) * MATH_W'(US_PER_CS);
  assign ilim_w = (MATH_W'(cfg_q[SLOT_MAX_FREQ]) * MATH_W'(cfg_q[SLOT_ILIM])) /
                  MATH_W'(PCT_DIV); // RQ8
  assign olim_w = (MATH_W'(cfg_q[SLOT_MAX_FREQ]) * MATH_W'(cfg_q[SLOT_OLIM])) /
                  MATH_W'(PCT_DIV); // RQ9

  // ==========================================================================
  // shared divider: integral over integral time, then derivative over sample time
  assign acc_mag_w = acc_q[MATH_W-1] ? MATH_W'(-acc_q) : MATH_W'(acc_q);
  assign dlt_mag_w = dlt_q[MATH_W-1] ? MATH_W'(-dlt_q) : MATH_W'(dlt_q);
  assign div_start_w = (state_q == ST_START_I) || (state_q == ST_START_D);
  assign div_num_w = (state_q == ST_START_I) ? acc_mag_w :
                     dlt_mag_w * MATH_W'(cfg_q[SLOT_TD]) * MATH_W'(US_PER_CS); // RQ6
  assign div_den_w = (state_q == ST_START_I) ? MATH_W'(ti_us_w) : MATH_W'(SAMPLE_TIME_US);

  pidsc_divider #(
    .W(MATH_W)
  ) u_div (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .i_start(div_start_w),
    .i_num(div_num_w),
    .i_den(div_den_w),
    .o_done(div_done_w),
    .o_quot(div_quot_w)
  );

  // integral saturation and output saturation
  pidsc_clamp #(
    .W(MATH_W)
  ) u_i_clamp (
    .i_val(i_raw_q),
    .i_lo(-ilim_w),
    .i_hi(ilim_w),
    .o_val(i_cl_w),
    .o_hit(i_hit_w)
  );

  assign sum_w = p_q + i_cl_w + d_q; // RQ3

  pidsc_clamp #(
    .W(MATH_W)
  ) u_out_clamp (
    .i_val(sum_w),
    .i_lo('0),
    .i_hi(olim_w),
    .o_val(out_w),
    .o_hit()
  );

  // ==========================================================================
  // sequencer: about 2 * MATH_W + 8 cycles per sample, well inside one period
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
    end else if (i_clk_en) begin
      case (state_q)
        ST_IDLE: state_q <= tick_q ? ST_CALC : ST_IDLE;
        ST_CALC: state_q <= ST_START_I;
        ST_START_I: state_q <= ST_WAIT_I;
        ST_WAIT_I: state_q <= div_done_w ? ST_START_D : ST_WAIT_I;
        ST_START_D: state_q <= ST_WAIT_D;
        ST_WAIT_D: state_q <= div_done_w ? ST_SUM : ST_WAIT_D;
        ST_SUM: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // error history and proportional term, captured once per sample
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      err_q <= '0;
      prev_err_q <= '0; // RQ12
      dlt_q <= '0;
      p_q <= '0;
    end else if (i_clk_en && state_q == ST_CALC) begin
      err_q <= err_w;
      prev_err_q <= err_w;
      dlt_q <= err_w - prev_err_q; // RQ6
      p_q <= p_w; // RQ1
    end
  end

  // integral accumulator holds the sum of error times sample time in microseconds
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      acc_q <= '0; // RQ12
    end else if (i_clk_en) begin
      if (cfg_q[SLOT_TI] == '0) begin
        acc_q <= '0; // RQ4
      end else if (state_q == ST_CALC) begin
        acc_q <= acc_q + err_w * MATH_W'(SAMPLE_TIME_US); // RQ5 RQ10
      end else if (state_q == ST_SUM && i_hit_w) begin
        acc_q <= i_cl_w * ti_us_w; // RQ8 anti-windup: stop growing past the bound
      end
    end
  end

  // divider results, signed back; the integral result is gated by its enabling setting
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      acc_neg_q <= 1'b0;
      i_raw_q <= '0;
      d_q <= '0;
    end else if (i_clk_en) begin
      if (state_q == ST_START_I) begin
        acc_neg_q <= acc_q[MATH_W-1];
      end
      if (state_q == ST_WAIT_I && div_done_w) begin
        i_raw_q <= (cfg_q[SLOT_TI] == '0) ? '0 : // RQ4
                   acc_neg_q ? -$signed(div_quot_w) : $signed(div_quot_w); // RQ5
      end
      if (state_q == ST_WAIT_D && div_done_w) begin
        d_q <= dlt_q[MATH_W-1] ? -$signed(div_quot_w) : $signed(div_quot_w); // RQ6
      end
    end
  end

  // outputs, all registered
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      i_term_q <= '0;
      o_freq_cmd <= '0;
      o_update <= 1'b0;
    end else if (i_clk_en) begin
      o_update <= state_q == ST_SUM;
      if (state_q == ST_SUM) begin
        i_term_q <= i_cl_w; // RQ8
        o_freq_cmd <= out_w[FREQ_W-1:0]; // RQ9
      end
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst || !i_clk_en);

  sequence calc_begins_s;
    tick_q && state_q == ST_IDLE ##1 state_q == ST_CALC;
  endsequence

  sequence sum_done_s;
    state_q == ST_SUM ##1 o_update;
  endsequence

  unity_gain_a: assert property (state_q == ST_CALC && !fine_gain_w && // RQ1
    cfg_q[SLOT_KP] == 16'h000A |=> p_q == err_q)
    else $error("gain setting 1.0 does not give unity gain");
  fine_gain_a: assert property (state_q == ST_CALC && fine_gain_w && // RQ2
    cfg_q[SLOT_KP] == 16'h0064 |=> p_q == err_q)
    else $error("fine gain format does not scale by hundredths");
  p_only_a: assert property (state_q == ST_SUM && cfg_q[SLOT_TI] == '0 && // RQ3
    cfg_q[SLOT_TD] == '0 && dlt_q == '0 |-> sum_w == p_q)
    else $error("output is not the proportional term alone");
  i_off_a: assert property (state_q == ST_CALC && cfg_q[SLOT_TI] == '0 // RQ4
    |=> acc_q == '0 ##[1:200] state_q == ST_SUM && i_raw_q == '0)
    else $error("integral term active with zero integral time");
  i_hold_a: assert property (state_q == ST_CALC && err_w == '0 && // RQ5
    cfg_q[SLOT_TI] != '0 |=> $stable(acc_q))
    else $error("integral moved while error is zero");
  d_zero_a: assert property (state_q == ST_WAIT_D && div_done_w && dlt_q == '0 // RQ6
    |=> d_q == '0)
    else $error("derivative nonzero without error change");
  i_accum_a: assert property (state_q == ST_CALC && cfg_q[SLOT_TI] != '0 // RQ10
    |=> acc_q == $past(acc_q) + $past(err_w) * MATH_W'(SAMPLE_TIME_US))
    else $error("integral did not add error times sample time");
  i_clamp_a: assert property (sum_done_s |-> i_term_q <= $past(ilim_w) && // RQ8
    i_term_q >= -$past(ilim_w))
    else $error("integral term exceeds its bound");
  out_clamp_a: assert property (o_update |-> // RQ9
    MATH_W'(o_freq_cmd) <= $past(olim_w))
    else $error("frequency command exceeds output limit");
  err_sign_a: assert property (state_q == ST_CALC && cfg_q[SLOT_FB_SRC] == 16'h0001 // RQ11
    |=> err_q == $past(MATH_W'(i_set_point)) - $past(MATH_W'(i_feedback)))
    else $error("negative feedback error is not set point minus feedback");
  sample_rate_a: assert property (calc_begins_s |-> ##[1:200] o_update) // RQ12
    else $error("sample update did not complete");
  wait_once_a: assert property (req_w && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus request not answered after one wait cycle");

endmodule : pidsc_speed_ctrl
`default_nettype wire

// ==== pidsc_pkg.sv ====
// pidsc_pkg: shared constants and types for the pid speed controller
package pidsc_pkg;

  // ==========================================================================
  // bus and datapath widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int MATH_W = 48;
  localparam int NUM_CFG = 8;

  // ==========================================================================
  // register indices; the byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_FB_SRC = 16'h0800;
  localparam logic [ADDR_W-1:0] IDX_KP = 16'h0801;
  localparam logic [ADDR_W-1:0] IDX_TI = 16'h0802;
  localparam logic [ADDR_W-1:0] IDX_TD = 16'h0803;
  localparam logic [ADDR_W-1:0] IDX_ILIM = 16'h0804;
  localparam logic [ADDR_W-1:0] IDX_OLIM = 16'h0805;
  localparam logic [ADDR_W-1:0] IDX_GAIN_FMT = 16'h0817;
  localparam logic [ADDR_W-1:0] IDX_MAX_FREQ = 16'h0100;
  localparam logic [ADDR_W-1:0] IDX_FREQ_OUT = 16'h08F0;
  localparam logic [ADDR_W-1:0] IDX_I_TERM = 16'h08F1;
  localparam int ADDR_SHIFT = 2;

  // configuration slots, in the order of the two tables below
  localparam int SLOT_FB_SRC = 0;
  localparam int SLOT_KP = 1;
  localparam int SLOT_TI = 2;
  localparam int SLOT_TD = 3;
  localparam int SLOT_ILIM = 4;
  localparam int SLOT_OLIM = 5;
  localparam int SLOT_GAIN_FMT = 6;
  localparam int SLOT_MAX_FREQ = 7;

  localparam logic [ADDR_W-1:0] CFG_IDX [NUM_CFG] = '{IDX_FB_SRC, IDX_KP, IDX_TI, IDX_TD,
    IDX_ILIM, IDX_OLIM, IDX_GAIN_FMT, IDX_MAX_FREQ};
  // reset values: gain 1.0, integral 1.00 s, no derivative, both limits 100.0 %, 60.00 Hz
  localparam logic [REG_W-1:0] CFG_RST [NUM_CFG] = '{16'h0000, 16'h000A, 16'h0064, 16'h0000,
    16'h03E8, 16'h03E8, 16'h0000, 16'h1770};

  // ==========================================================================
  // field positions and codes
  localparam int GAIN_FMT_BIT = 1;
  localparam logic [REG_W-1:0] FB_NONE = 16'h0000;
  localparam logic [REG_W-1:0] FB_POS_ANALOG = 16'h0004;
  localparam logic [REG_W-1:0] FB_POS_PULSE = 16'h0005;
  localparam logic [REG_W-1:0] FB_POS_PULSE_DIR = 16'h0006;
  localparam logic [REG_W-1:0] FB_POS_COMM = 16'h0008;

  // ==========================================================================
  // scaling: gain in 0.1 or 0.01, times in 0.01 s, percentages in 0.1 %
  localparam int KP_DIV_TENTHS = 10;
  localparam int KP_DIV_HUNDREDTHS = 100;
  localparam int PCT_DIV = 1000;
  localparam int US_PER_CS = 10000;

  // ==========================================================================
  // timing
  localparam int CLK_MHZ = 25;
  localparam int SAMPLE_TIME_US = 1000;
  localparam int SAMPLE_CYCLES_DFLT = SAMPLE_TIME_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CALC, ST_START_I, ST_WAIT_I, ST_START_D, ST_WAIT_D, ST_SUM
  } pidsc_state_t;

endpackage : pidsc_pkg

// ==== pidsc_divider.sv ====
// pidsc_divider: sequential restoring divider for unsigned magnitudes
`timescale 1ns/10ps
`default_nettype none
module pidsc_divider #(
  parameter int W = 48
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_start,
  input wire logic [W-1:0] i_num,
  input wire logic [W-1:0] i_den,
  output logic o_done,
  output logic [W-1:0] o_quot
);

  // ==========================================================================
  // one quotient bit per cycle; a divide takes W cycles plus one
  logic [W:0] rem_q;
  logic [W:0] rem_sh_w;
  logic [W-1:0] den_q;
  logic [$clog2(W+1)-1:0] cnt_q;
  logic busy_q;
  logic done_q;
  logic take_w;

  assign rem_sh_w = {rem_q[W-1:0], o_quot[W-1]};
  assign take_w = rem_sh_w >= {1'b0, den_q};
  assign o_done = done_q;

  // iteration registers; a zero divisor yields all ones, callers guard it
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rem_q <= '0;
      den_q <= '0;
      o_quot <= '0;
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (i_clk_en) begin
      done_q <= busy_q && (cnt_q == 1);
      if (i_start) begin
        rem_q <= '0;
        den_q <= i_den;
        o_quot <= i_num;
        cnt_q <= ($clog2(W+1))'(W);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        rem_q <= take_w ? rem_sh_w - {1'b0, den_q} : rem_sh_w;
        o_quot <= {o_quot[W-2:0], take_w};
        cnt_q <= cnt_q - 1'b1;
        busy_q <= cnt_q != 1;
      end
    end
  end

endmodule : pidsc_divider
`default_nettype wire

// ==== pidsc_clamp.sv ====
// pidsc_clamp: signed saturation between a lower and an upper bound
`timescale 1ns/10ps
`default_nettype none
module pidsc_clamp #(
  parameter int W = 48
) (
  input wire logic signed [W-1:0] i_val,
  input wire logic signed [W-1:0] i_lo,
  input wire logic signed [W-1:0] i_hi,
  output logic signed [W-1:0] o_val,
  output logic o_hit
);

  // ==========================================================================
  // upper bound is tested first, so any value above it gives it even if the bounds cross; a zero limit gives zero
  logic over_w;
  logic under_w;

  assign over_w = i_val > i_hi;
  assign under_w = i_val < i_lo;
  assign o_val = over_w ? i_hi : (under_w ? i_lo : i_val);
  assign o_hit = over_w || under_w;

endmodule : pidsc_clamp
`default_nettype wire

// ==== pidsc_sensor_model.sv ====
// pidsc_sensor_model: far-side model of the sensor path and motor command input
`timescale 1ns/10ps
`default_nettype none
module pidsc_sensor_model
  import pidsc_pkg::*;
#(
  parameter int FREQ_W = 17
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [REG_W-1:0] i_sp_target,
  input wire logic [REG_W-1:0] i_fb_target,
  input wire logic [FREQ_W-1:0] i_freq_cmd,
  input wire logic i_update,
  output logic [REG_W-1:0] o_set_point,
  output logic [REG_W-1:0] o_feedback,
  output logic [FREQ_W-1:0] o_last_cmd
);
  // ==========================================================================
  // sensor values move only just after an edge, like a synchronous sensor front end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_set_point <= '0;
      o_feedback <= '0;
      o_last_cmd <= '0;
    end else begin
      o_set_point <= i_sp_target;
      o_feedback <= i_fb_target;
      // the motor side latches the command only on the update pulse
      if (i_update) begin
        o_last_cmd <= i_freq_cmd;
      end
    end
  end
endmodule : pidsc_sensor_model
`default_nettype wire

// ==== pidsc_speed_ctrl_tb.sv ====
// pidsc_speed_ctrl_tb: register-bus driven checks of the pid speed controller
`timescale 1ns/10ps
`default_nettype none
module pidsc_speed_ctrl_tb import pidsc_pkg::*;;
  // ==========================================================================
  // short sample period keeps the run brief; all expectations are per sample
  localparam int SAMPLES = 200;
  localparam int FW = 17;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] address = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic wait_req;
  logic [REG_W-1:0] sp_tgt = '0;
  logic [REG_W-1:0] fb_tgt = '0;
  logic [REG_W-1:0] sp;
  logic [REG_W-1:0] fb;
  logic [FW-1:0] freq_cmd;
  logic [FW-1:0] last_cmd;
  logic update;
  logic [DATA_W-1:0] rd_val;
  logic [3:0] be = 4'hF;
  logic en = 1'b1;
  int n_upd = 0;
  int failures = 0;
  int num_checks = 0;
  // p-path table: source, gain, format, output limit, set point, feedback, command
  logic [REG_W-1:0] t_src [6] = '{16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0004, 16'h0001};
  logic [REG_W-1:0] t_kp [6] = '{16'h0005, 16'h0064, 16'h2710, 16'h2710, 16'h0005, 16'h000A};
  logic [REG_W-1:0] t_fmt [6] = '{16'h0000, 16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [REG_W-1:0] t_olim [6] = '{16'h03E8, 16'h03E8, 16'h03E8, 16'h044C, 16'h03E8, 16'h03E8};
  logic [REG_W-1:0] t_sp [6] = '{16'h03E8, 16'h03E8, 16'h03E8, 16'h03E8, 16'h03E8, 16'h0190};
  logic [REG_W-1:0] t_fb [6] = '{16'h0190, 16'h0190, 16'h0190, 16'h0190, 16'h0190, 16'h03E8};
  logic [FW-1:0] t_exp [6] = '{17'h0012C, 17'h00258, 17'h01770, 17'h019C8, 17'h002BC, 17'h00000};

  always #20 clk = ~clk;

  pidsc_speed_ctrl #(
    .SAMPLE_CYCLES(SAMPLES),
    .FREQ_W(FW)
  ) u_dut (
    .i_sys_clk(clk),
    .i_rst(rst),
    .i_clk_en(en),
    .i_avs_address(address),
    .i_avs_read(rd),
    .i_avs_write(wr),
    .i_avs_writedata(wdata),
    .i_avs_byteenable(be),
    .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req),
    .i_set_point(sp),
    .i_feedback(fb),
    .o_freq_cmd(freq_cmd),
    .o_update(update)
  );

  pidsc_sensor_model #(
    .FREQ_W(FW)
  ) u_sensor (
    .i_sys_clk(clk),
    .i_rst(rst),
    .i_sp_target(sp_tgt),
    .i_fb_target(fb_tgt),
    .i_freq_cmd(freq_cmd),
    .i_update(update),
    .o_set_point(sp),
    .o_feedback(fb),
    .o_last_cmd(last_cmd)
  );

  // ==========================================================================
  // verdict and comparison
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // one avalon access; held until waitrequest is seen low, then one idle edge
  task automatic bus(input logic is_wr, input logic [ADDR_W-1:0] idx, input logic [REG_W-1:0] v);
    int n;
    n = 0;
    address <= idx << ADDR_SHIFT;
    wdata <= {16'h0000, v};
    wr <= is_wr;
    rd <= ~is_wr;
    @(posedge clk);
    while (wait_req !== 1'b0) begin
      n++;
      if (n > 20) begin
        failures++;
        tally_and_finish();
      end
      @(posedge clk);
    end
    rd_val = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : bus

  // wait k update pulses, then compare what the motor side latched
  task automatic expect_cmd(input string what, input int k, input logic [FW-1:0] exp);
    int n;
    repeat (k) begin
      n = 0;
      @(posedge clk);
      while (update !== 1'b1) begin
        n++;
        if (n > 1000) begin
          failures++;
          tally_and_finish();
        end
        @(posedge clk);
      end
    end
    @(posedge clk);
    check(what, {15'h0000, last_cmd}, {15'h0000, exp});
  endtask : expect_cmd

  task automatic do_reset();
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    check("cmd in reset", {15'h0000, freq_cmd}, 32'h00000000);
    rst <= 1'b0;
    @(posedge clk);
  endtask : do_reset

  // writes land well before the first sample tick after reset
  task automatic cfg(input logic [REG_W-1:0] src, kp, ti, td, ilim, olim, fmt);
    bus(1'b1, IDX_FB_SRC, src);
    bus(1'b1, IDX_KP, kp);
    bus(1'b1, IDX_TI, ti);
    bus(1'b1, IDX_TD, td);
    bus(1'b1, IDX_ILIM, ilim);
    bus(1'b1, IDX_OLIM, olim);
    bus(1'b1, IDX_GAIN_FMT, fmt);
  endtask : cfg

  // ==========================================================================
  // main sequence
  initial begin
    do_reset();
    for (int k = 0; k < NUM_CFG; k++) begin
      bus(1'b0, CFG_IDX[k], 16'h0000);
      check("reset value", rd_val, {16'h0000, CFG_RST[k]});
    end
    bus(1'b1, IDX_TD, 16'h0032);
    bus(1'b0, IDX_TD, 16'h0000);
    check("td readback", rd_val, 32'h00000032);
    // only the low byte lane is enabled, so the upper byte must be kept
    be <= 4'h1;
    bus(1'b1, IDX_TD, 16'hAB07);
    be <= 4'hF;
    bus(1'b0, IDX_TD, 16'h0000);
    check("td byte lane", rd_val, 32'h00000007);
    bus(1'b1, IDX_FREQ_OUT, 16'h1234);
    bus(1'b0, IDX_FREQ_OUT, 16'h0000);
    check("cmd read-only", rd_val, 32'h00000000);
    bus(1'b0, 16'h0900, 16'h0000);
    check("unmapped read", rd_val, 32'h00000000);
    $display("test registers done");
    // proportional path, then gain formats, limits and feedback polarity
    sp_tgt <= 16'h03E8;
    fb_tgt <= 16'h0190;
    do_reset();
    cfg(16'h0001, 16'h000A, 16'h0000, 16'h0000, 16'h03E8, 16'h03E8, 16'h0000);
    expect_cmd("p only", 1, 17'h00258);
    for (int r = 0; r < 6; r++) begin
      bus(1'b1, IDX_FB_SRC, t_src[r]);
      bus(1'b1, IDX_KP, t_kp[r]);
      bus(1'b1, IDX_GAIN_FMT, t_fmt[r]);
      bus(1'b1, IDX_OLIM, t_olim[r]);
      sp_tgt <= t_sp[r];
      fb_tgt <= t_fb[r];
      expect_cmd("p row", 2, t_exp[r]);
    end
    $display("test proportional done");
    // integral builds 5 per sample and stops at 1.0 % of 60.00 Hz
    sp_tgt <= 16'h1388;
    fb_tgt <= 16'h0000;
    do_reset();
    cfg(16'h0001, 16'h0000, 16'h0064, 16'h0000, 16'h000A, 16'h03E8, 16'h0000);
    expect_cmd("integral 1", 1, 17'h00005);
    expect_cmd("integral 2", 1, 17'h0000A);
    expect_cmd("integral clamp", 12, 17'h0003C);
    bus(1'b0, IDX_I_TERM, 16'h0000);
    check("i term", rd_val, 32'h0000003C);
    do_reset();
    cfg(16'h0001, 16'h0000, 16'h0032, 16'h0000, 16'h000A, 16'h03E8, 16'h0000);
    expect_cmd("integral short", 1, 17'h0000A);
    bus(1'b1, IDX_TI, 16'h0000);
    expect_cmd("integral off", 2, 17'h00000);
    $display("test integral done");
    // derivative always paired with p: a step then a steady error
    sp_tgt <= 16'h0005;
    do_reset();
    cfg(16'h0001, 16'h000A, 16'h0000, 16'h0064, 16'h03E8, 16'h03E8, 16'h0000);
    expect_cmd("p plus d", 1, 17'h0138D);
    expect_cmd("d settled", 1, 17'h00005);
    // clock enable low for two sample periods: no update, command held
    en <= 1'b0;
    repeat (400) begin
      @(posedge clk);
      n_upd += update;
    end
    en <= 1'b1;
    check("frozen updates", n_upd, 32'h00000000);
    check("frozen cmd", {15'h0000, freq_cmd}, 32'h00000005);
    $display("test derivative done");
    tally_and_finish();
  end
endmodule : pidsc_speed_ctrl_tb
`default_nettype wire
